// ==== rtl/sntx_pkg.sv ====
package sntx_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL1 = 6'h00;
  localparam logic [5:0] OFS_TICK  = 6'h04;
  localparam logic [5:0] OFS_FRAME = 6'h08;
  localparam logic [5:0] OFS_DATL  = 6'h0c;
  localparam logic [5:0] OFS_DATH  = 6'h10;
  localparam logic [5:0] OFS_ISTAT = 6'h14;
  localparam logic [5:0] OFS_IMASK = 6'h18;
  localparam logic [5:0] OFS_TRIG  = 6'h1c;
  localparam logic [5:0] OFS_STATE = 6'h20;
  // Control 1 field positions
  localparam int NIB_LSB = 0;
  localparam int PPE_BIT = 7;
  localparam int CRC_BIT = 8;
  localparam int TXM_BIT = 10;
  localparam int RCV_BIT = 11;
  localparam int EN_BIT  = 15;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVR  = 1;
  localparam int IRQ_W    = 2;
  // Frame timing in ticks, nibble count limits, CRC constants
  localparam logic [9:0]  SYNC_TICKS = 10'h038;
  localparam logic [9:0]  NIB_BASE   = 10'h00c;
  localparam logic [9:0]  PAUSE_MIN  = 10'h00c;
  localparam logic [9:0]  PAUSE_MAX  = 10'h300;
  localparam logic [9:0]  LOW_TICKS  = 10'h005;
  localparam logic [11:0] FRAME_MAX  = 12'h7ff;
  localparam logic [2:0]  NIB_MIN    = 3'h1;
  localparam logic [2:0]  NIB_MAX    = 3'h6;
  localparam logic [3:0]  CRC_SEED   = 4'h5;
  localparam logic [3:0]  CRC_POLY   = 4'hd;
  // Reset values
  localparam logic [15:0] TICK_RST   = 16'h0000;
  localparam logic [15:0] FRAME_RST  = 16'h0000;

  typedef struct packed {
    logic       module_enable_bit;
    logic       receive_select_bit;
    logic       transmit_sync_select;
    logic       hw_crc_enable;
    logic       pause_pulse_enable;
    logic [2:0] nibble_count_field;
  } sntx_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SYNC  = 2'b01,
    ST_NIB   = 2'b10,
    ST_PAUSE = 2'b11
  } sntx_state_t;
endpackage

// ==== rtl/sntx_top.sv ====
// Summary of operation
// - After reset, transmit operation is selected
// - Continuous asynchronous or software-triggered frames
// - Sync 56 ticks, status, data, CRC, pause
// - Tick lasts tick field plus one clocks
// - Async pause pads frame to frame field
// - Pause always between 12 and 768 ticks
// - Frame field above 2047 acts as 2047
// - Nibble count field sets 1 to 6
// - Receive select bit clear means transmit
// - Sync select bit picks triggered sending
// - CRC enable picks hardware or software CRC
// - Pause enable bit adds pause pulse in async mode only
// - Sending starts only once enable is set
// - Frame completion raises an interrupt
`timescale 1ns/10ps
`default_nettype none
module sntx_top
  import sntx_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  // Avalon-MM slave
  input  wire logic [5:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Link and interrupt
  output logic             SENT_TX_O,
  output logic             IRQ_O
);
  import sntx_pkg::*;

  sntx_ctrl_t      ctrl_reg;
  sntx_state_t     state_reg;
  logic [15:0]     tick_reg, frame_reg, datl_reg, dath_reg;
  logic [IRQ_W-1:0] stat_reg, mask_reg, ev;
  logic            trig_reg, wait_reg, irq_reg, tx_reg;
  logic [31:0]     rdata_reg, word_reg;
  logic [15:0]     div_reg;
  logic [9:0]      cnt_reg, len_reg;
  logic [11:0]     el_reg;
  logic [2:0]      idx_reg;
  logic [3:0]      crc_reg;
  logic            wr_acc, tick_en, iv_end, run_ok, async_run;
  logic            start, last_nib, pause_go;
  logic [2:0]      n_eff;
  logic [3:0]      crc_next, nib_val;
  logic [12:0]     pause_raw;
  logic [9:0]      pause_len;
  logic [11:0]     frame_cap;

  assign AVS_READDATA_O    = rdata_reg;
  assign AVS_WAITREQUEST_O = wait_reg;
  assign SENT_TX_O         = tx_reg;
  assign IRQ_O             = irq_reg;

  function automatic logic [3:0] crc_of(input logic [31:0] w,
                                        input logic [2:0] n);
    logic [3:0] c;
    logic [3:0] d;
    logic       fb;
    c = CRC_SEED;
    for (int i = 1; i <= 7; i++) begin
      d = (i <= int'(n)) ? w[31-4*i -: 4] : 4'h0;
      if (i <= int'(n) || i == 7) begin
        for (int b = 3; b >= 0; b--) begin
          fb = c[3];
          c  = {c[2:0], d[b]};
          if (fb) begin
            c = c ^ CRC_POLY;
          end
        end
      end
    end
    return c;
  endfunction

  // Bus handshake, one wait state
  assign wr_acc = AVS_WRITE_I & ~wait_reg;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~((AVS_READ_I | AVS_WRITE_I) & wait_reg);
    end
  end

  // Configuration registers
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ctrl_reg  <= '0;
      tick_reg  <= TICK_RST;
      frame_reg <= FRAME_RST;
      datl_reg  <= '0;
      dath_reg  <= '0;
      mask_reg  <= '0;
    end else if (wr_acc) begin
      unique case (AVS_ADDRESS_I)
        OFS_CTRL1: ctrl_reg <= '{AVS_WRITEDATA_I[EN_BIT],
                                 AVS_WRITEDATA_I[RCV_BIT],
                                 AVS_WRITEDATA_I[TXM_BIT],
                                 AVS_WRITEDATA_I[CRC_BIT],
                                 AVS_WRITEDATA_I[PPE_BIT],
                                 AVS_WRITEDATA_I[NIB_LSB +: 3]};
        OFS_TICK:  tick_reg  <= AVS_WRITEDATA_I[15:0];
        OFS_FRAME: frame_reg <= AVS_WRITEDATA_I[15:0];
        OFS_DATL:  datl_reg  <= AVS_WRITEDATA_I[15:0];
        OFS_DATH:  dath_reg  <= AVS_WRITEDATA_I[15:0];
        OFS_IMASK: mask_reg  <= AVS_WRITEDATA_I[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux, unmapped reads zero
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rdata_reg <= '0;
    end else begin
      unique case (AVS_ADDRESS_I)
        OFS_CTRL1: rdata_reg <= 32'(
          {ctrl_reg.module_enable_bit, 3'h0,
           ctrl_reg.receive_select_bit, ctrl_reg.transmit_sync_select,
           1'b0, ctrl_reg.hw_crc_enable, ctrl_reg.pause_pulse_enable,
           4'h0, ctrl_reg.nibble_count_field});
        OFS_TICK:  rdata_reg <= 32'(tick_reg);
        OFS_FRAME: rdata_reg <= 32'(frame_reg);
        OFS_DATL:  rdata_reg <= 32'(datl_reg);
        OFS_DATH:  rdata_reg <= 32'(dath_reg);
        OFS_ISTAT: rdata_reg <= 32'(stat_reg);
        OFS_IMASK: rdata_reg <= 32'(mask_reg);
        OFS_TRIG:  rdata_reg <= 32'(trig_reg);
        OFS_STATE: rdata_reg <= 32'({idx_reg, state_reg});
        default:   rdata_reg <= '0;
      endcase
    end
  end

  // Frame control terms
  assign run_ok    = ctrl_reg.module_enable_bit &
                     ~ctrl_reg.receive_select_bit;
  assign async_run = run_ok & ~ctrl_reg.transmit_sync_select;
  assign n_eff     = (ctrl_reg.nibble_count_field < NIB_MIN) ? NIB_MIN :
                     (ctrl_reg.nibble_count_field > NIB_MAX) ? NIB_MAX :
                     ctrl_reg.nibble_count_field;
  assign tick_en   = (state_reg != ST_IDLE) && (div_reg == tick_reg);
  assign iv_end    = tick_en && (cnt_reg == len_reg - 10'h001);
  assign last_nib  = (idx_reg == n_eff + 3'h1);
  assign pause_go  = async_run & ctrl_reg.pause_pulse_enable;
  assign start     = run_ok && (ctrl_reg.transmit_sync_select ?
                                trig_reg : 1'b1);
  assign crc_next  = ctrl_reg.hw_crc_enable ?
                     crc_of({dath_reg, datl_reg}, n_eff) :
                     datl_reg[3:0];
  assign frame_cap = (frame_reg > 16'(FRAME_MAX)) ? FRAME_MAX :
                     frame_reg[11:0];
  assign pause_raw = {1'b0, frame_cap} - {1'b0, el_reg} - 13'h0001;
  assign pause_len = (pause_raw[12] || pause_raw < 13'(PAUSE_MIN)) ?
                     PAUSE_MIN :
                     (pause_raw > 13'(PAUSE_MAX)) ? PAUSE_MAX :
                     pause_raw[9:0];
  assign nib_val   = (idx_reg + 3'h1 == n_eff + 3'h1) ? crc_reg :
                     word_reg[31 - 4*(int'(idx_reg) + 1) -: 4];

  // Tick divider
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || state_reg == ST_IDLE || tick_en) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // Frame sequencer
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      len_reg   <= '0;
      el_reg    <= '0;
      idx_reg   <= '0;
      word_reg  <= '0;
      crc_reg   <= '0;
    end else if (!run_ok) begin
      state_reg <= ST_IDLE;
    end else if ((state_reg == ST_IDLE && start) ||
                 (iv_end && ((state_reg == ST_PAUSE) ||
                  (state_reg == ST_NIB && last_nib && !pause_go)) &&
                  start)) begin
      state_reg <= ST_SYNC;
      len_reg   <= SYNC_TICKS;
      cnt_reg   <= '0;
      el_reg    <= '0;
      idx_reg   <= '0;
      word_reg  <= {dath_reg, datl_reg};
      crc_reg   <= crc_next;
    end else if (iv_end) begin
      cnt_reg <= '0;
      el_reg  <= el_reg + 12'h001;
      unique case (state_reg)
        ST_SYNC: begin
          state_reg <= ST_NIB;
          len_reg   <= NIB_BASE + 10'(word_reg[31:28]);
        end
        ST_NIB: begin
          if (!last_nib) begin
            idx_reg <= idx_reg + 3'h1;
            len_reg <= NIB_BASE + 10'(nib_val);
          end else if (pause_go) begin
            state_reg <= ST_PAUSE;
            len_reg   <= pause_len;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_PAUSE: state_reg <= ST_IDLE;
        ST_IDLE:  state_reg <= ST_IDLE;
      endcase
    end else if (tick_en) begin
      cnt_reg <= cnt_reg + 10'h001;
      el_reg  <= el_reg + 12'h001;
    end
  end

  // Line driver, low pulse at each interval start
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      tx_reg <= 1'b1;
    end else begin
      tx_reg <= !(state_reg != ST_IDLE && cnt_reg < LOW_TICKS);
    end
  end

  // Software trigger, held until a frame starts
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      trig_reg <= 1'b0;
    end else if (wr_acc && AVS_ADDRESS_I == OFS_TRIG &&
                 AVS_WRITEDATA_I[0]) begin
      trig_reg <= 1'b1;
    end else if (run_ok && state_reg == ST_IDLE) begin
      trig_reg <= 1'b0;
    end else if (iv_end && state_reg != ST_SYNC &&
                 (state_reg == ST_PAUSE || (last_nib && !pause_go))) begin
      trig_reg <= 1'b0;
    end
  end

  // Interrupt status, set wins over clear
  assign ev[IRQ_DONE] = iv_end && state_reg == ST_NIB && last_nib;
  assign ev[IRQ_OVR]  = wr_acc && AVS_ADDRESS_I == OFS_TRIG &&
                        AVS_WRITEDATA_I[0] && trig_reg;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      stat_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= ev | (stat_reg & ~((wr_acc && AVS_ADDRESS_I == OFS_ISTAT)
                  ? AVS_WRITEDATA_I[IRQ_W-1:0] : '0));
      irq_reg  <= |(stat_reg & mask_reg);
    end
  end

  // Assertion helpers
  logic [15:0] gap_cnt;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || tick_en || state_reg == ST_IDLE) begin
      gap_cnt <= '0;
    end else begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  a_reset_tx_mode: assert property (
    @(posedge CLK_I)
    !$past(RESETN_I) && RESETN_I |-> !ctrl_reg.receive_select_bit &&
      state_reg == ST_IDLE && SENT_TX_O)
    else $error("not idle in transmit mode after reset");
  a_sync_len: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    state_reg == ST_SYNC |-> len_reg == SYNC_TICKS)
    else $error("sync interval not 56 ticks");
  a_nib_value: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    state_reg == ST_NIB |-> len_reg >= NIB_BASE &&
      len_reg <= NIB_BASE + 10'h00f)
    else $error("nibble interval out of range");
  a_tick_period: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    tick_en && $stable(tick_reg) |-> gap_cnt == tick_reg)
    else $error("tick spacing wrong");
  a_pause_bounds: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    state_reg == ST_PAUSE |-> len_reg >= PAUSE_MIN &&
      len_reg <= PAUSE_MAX)
    else $error("pause length out of range");
  a_pause_async: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    $rose(state_reg == ST_PAUSE) |-> $past(pause_go))
    else $error("pause outside async pause mode");
  a_frame_cap: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    $rose(state_reg == ST_PAUSE) |-> len_reg == PAUSE_MIN ||
      12'(len_reg) + el_reg <= FRAME_MAX)
    else $error("frame longer than cap");
  a_nib_count: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    state_reg == ST_NIB |-> idx_reg <= n_eff + 3'h1)
    else $error("too many nibbles");
  a_enable_start: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    state_reg == ST_IDLE ##1 state_reg == ST_SYNC |-> $past(run_ok))
    else $error("frame began while disabled");
  a_done_irq: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    ev[IRQ_DONE] && mask_reg[IRQ_DONE] |-> ##2 IRQ_O)
    else $error("frame completion irq missing");
  a_sync_trig: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    state_reg == ST_IDLE && ctrl_reg.transmit_sync_select && !trig_reg
      |=> state_reg == ST_IDLE)
    else $error("sync mode started without trigger");
  a_ovr_flag: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    ev[IRQ_OVR] |=> stat_reg[IRQ_OVR])
    else $error("trigger overrun not flagged");
  a_done_sticky: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    stat_reg[IRQ_DONE] && !(wr_acc && AVS_ADDRESS_I == OFS_ISTAT &&
      AVS_WRITEDATA_I[IRQ_DONE]) |=> stat_reg[IRQ_DONE])
    else $error("frame done flag lost without clear");
  a_irq_level: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (|(stat_reg & mask_reg)) |=> IRQ_O)
    else $error("irq low with unmasked status");
  a_irq_quiet: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    !(|(stat_reg & mask_reg)) |=> !IRQ_O)
    else $error("irq high with no unmasked status");
  a_idle_line: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    state_reg == ST_IDLE |=> SENT_TX_O)
    else $error("line low while idle");
  a_low_pulse: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    state_reg != ST_IDLE && cnt_reg < LOW_TICKS |=> !SENT_TX_O)
    else $error("interval start pulse missing");
endmodule
`default_nettype wire

// ==== tb/sntx_rx_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sntx_rx_model (
  // Clock and line
  input wire logic clk_i,
  input wire logic line_i
);
  logic [15:0] gaps[$];
  logic        prev;
  int          cnt;
  bit          armed;
  initial begin
    prev = 1'b1;
    cnt = 0;
    armed = 1'b0;
  end
  // Cycles between falling edges carry each value
  always @(posedge clk_i) begin
    cnt++;
    if (prev === 1'b1 && line_i === 1'b0) begin
      if (armed)
        gaps.push_back(cnt[15:0]);
      armed = 1'b1;
      cnt = 0;
    end
    prev = line_i;
  end
  // Forget history before a new frame train
  task automatic flush();
    armed = 1'b0;
    gaps.delete();
  endtask
endmodule
`default_nettype wire

// ==== tb/sntx_top_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module sntx_top_bench;
  import sntx_pkg::*;
  logic        clk, rst_n, rd, wr, irq, tx, wait_r;
  logic [5:0]  adr;
  logic [31:0] wd, rdata, got;
  int          n_errors, comparisons, p;
  logic [3:0]  c;
  int          fr[3] = '{200, 60, 3000};
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end

  sntx_top dut (.CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_r),
    .SENT_TX_O(tx), .IRQ_O(irq));
  sntx_rx_model rx (.clk_i(clk), .line_i(tx));

  always #2 clk = ~clk;

  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= {16'h0000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    got = rdata;
    if (n >= 20) begin
      n_errors++;
      stop_test();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic gaps(input int e[$], input int mul);
    int n;
    n = 0;
    while (rx.gaps.size() < e.size() && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      n_errors++;
      stop_test();
    end
    foreach (e[i]) `CHK("gap", 16'(e[i] * mul), rx.gaps[i])
  endtask

  // Restart with new data while the line is idle
  task automatic start(input logic [15:0] dh, input logic [15:0] dl,
                       input logic [15:0] ctl);
    bus(1'b1, OFS_CTRL1, 16'h0000);
    bus(1'b1, OFS_DATH, dh);
    bus(1'b1, OFS_DATL, dl);
    rx.flush();
    bus(1'b1, OFS_CTRL1, ctl);
  endtask

  function automatic logic [3:0] crc4(input logic [3:0] nib);
    logic [3:0] r;
    logic [7:0] s;
    logic       f;
    r = 4'h5;
    s = {nib, 4'h0};
    for (int i = 7; i >= 0; i--) begin
      f = r[3];
      r = {r[2:0], s[i]};
      if (f)
        r = r ^ 4'hd;
    end
    return r;
  endfunction

  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk);
    `CHK("irq", v, irq)
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 6'h00;
    wd = 32'h00000000;
    n_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("tx idle", 1'b1, tx)
    `CHK("irq", 1'b0, irq)
    bus(1'b0, OFS_CTRL1, 16'h0000);
    `CHK("ctrl1", 32'h00000000, got)
    bus(1'b0, 6'h3c, 16'h0000);
    `CHK("unmapped", 32'h00000000, got)
    // Async, two nibbles, software CRC, interrupt unmasked
    bus(1'b1, OFS_TICK, 16'h0000);
    bus(1'b1, OFS_IMASK, 16'h0001);
    bus(1'b1, OFS_DATH, 16'ha3f0);
    bus(1'b1, OFS_DATL, 16'h0007);
    repeat (20) @(posedge clk);
    `CHK("tx before enable", 1'b1, tx)
    start(16'ha3f0, 16'h0007, 16'h8002);
    gaps('{56, 22, 15, 27, 19, 56}, 1);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, OFS_CTRL1, 16'h0002);
    bus(1'b0, OFS_ISTAT, 16'h0000);
    `CHK("istat", 32'h00000001, got)
    bus(1'b1, OFS_IMASK, 16'h0000);
    irq_is(1'b0);
    bus(1'b1, OFS_IMASK, 16'h0001);
    irq_is(1'b1);
    bus(1'b1, OFS_ISTAT, 16'h0001);
    irq_is(1'b0);
    bus(1'b0, OFS_ISTAT, 16'h0000);
    `CHK("istat clr", 32'h00000000, got)
    // Pause pads frame, clamped 12..768, hardware CRC
    c = crc4(4'h9);
    foreach (fr[i]) begin
      bus(1'b1, OFS_FRAME, 16'(fr[i]));
      p = fr[i] - (106 + c);
      p = (p < 12) ? 12 : ((p > 768) ? 768 : p);
      start(16'h5900, 16'h0000, 16'h8181);
      gaps('{56, 17, 21, 12 + c, p, 56}, 1);
    end
    // Triggered frame: one frame only
    start(16'h5900, 16'h0000, 16'h8401);
    bus(1'b1, OFS_TRIG, 16'h0001);
    gaps('{56, 17, 21}, 1);
    repeat (1000) @(posedge clk);
    `CHK("one frame", 32'h3, 32'(rx.gaps.size()))
    bus(1'b1, OFS_TRIG, 16'h0001);
    bus(1'b1, OFS_TRIG, 16'h0001);
    bus(1'b1, OFS_TRIG, 16'h0001);
    bus(1'b0, OFS_ISTAT, 16'h0000);
    `CHK("overrun", 32'h00000003, got)
    // Four clocks per tick, six nibbles
    bus(1'b1, OFS_TICK, 16'h0003);
    bus(1'b0, OFS_TICK, 16'h0000);
    `CHK("tick", 32'h00000003, got)
    start(16'h0000, 16'h0000, 16'h8006);
    gaps('{56, 12, 12, 12, 12, 12, 12, 12, 12, 56}, 4);
    // Receive selected: line stays idle
    start(16'h0000, 16'h0000, 16'h8801);
    repeat (400) @(posedge clk);
    `CHK("rx quiet", 32'h0, 32'(rx.gaps.size()))
    `CHK("tx high", 1'b1, tx)
    bus(1'b0, OFS_STATE, 16'h0000);
    `CHK("state idle", 2'h0, got[1:0])
    stop_test();
  end
endmodule
`default_nettype wire
